// ### design/iasr_pkg.sv
package iasr_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_SHIFT  = 4'h8;
    localparam logic [3:0] ADDR_IRQ    = 4'hC;
    localparam int         ADDR_W      = 4;

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int CTRL_START  = 0;
    localparam int CTRL_STOP   = 1;
    localparam int CTRL_WAITT  = 2;
    localparam int CTRL_SPIE   = 3;
    localparam int CTRL_RELEASE = 4;
    localparam int CTRL_ADDR_LO = 8;
    localparam int CTRL_ADDR_HI = 14;
    localparam int CTRL_MASK_LO = 16;
    localparam int CTRL_MASK_HI = 19;

    // ----------------------------------------------------------------
    // Bus status fields
    // ----------------------------------------------------------------
    localparam int ST_STOP  = 0;
    localparam int ST_START = 1;
    localparam int ST_ACK   = 2;
    localparam int ST_TRC   = 3;
    localparam int ST_COI   = 4;
    localparam int ST_EXC   = 5;
    localparam int ST_ALD   = 6;
    localparam int ST_MST   = 7;

    // Interrupt status bits
    localparam int IRQ_XFER = 0;
    localparam int IRQ_ALD  = 1;
    localparam int IRQ_STOP = 2;
    localparam int IRQ_EXC  = 3;
    localparam int IRQ_N    = 4;

    localparam logic [3:0] BIT_ACK    = 4'h8;
    localparam logic [3:0] BIT_LAST   = 4'h9;
    localparam logic [3:0] BIT_ZERO   = 4'h0;
    localparam logic [3:0] SCL_HALF   = 4'h7;
    localparam logic [7:0] BYTE_ONES  = 8'hFF;
    localparam logic [3:0] EXT_PREFIX = 4'h0;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        IASR_IDLE, IASR_MSTART, IASR_ACTIVE, IASR_RESTART, IASR_MSTOP,
        IASR_LOST
    } iasr_state_t;

    typedef struct packed {
        logic [2:0] scl;
        logic [2:0] sda;
    } iasr_sync_t;

endpackage : iasr_pkg

// ### design/iasr_shifter.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Shift register advances on serial clock fall.
// - Transmit via output latch, MSB first.
// - Receive samples data on serial clock rise.
// - Master sends address, direction, then data.
// - Direction flag sits at status bit 3.
// - Stop interrupt only when stop enable set.
// - After loss continue as slave when addressed.
// - Loss during address: flag, release bus.
// - Loss during extension code flags extension.
// - Loss during data sets flag, interrupts.
// - Foreign restart during data counts as loss.
// - Foreign stop during data counts as loss.
// - Data low during own restart: loss.
// - Foreign stop during own restart: loss.
// - Data low during own stop: loss, interrupt.
// - Loser during data stays quiet until start or stop.
module iasr_shifter (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        serialClockLineIn,
    output var  logic        serialClockLineOut,
    output var  logic        serialClockLineOe,
    input  wire logic        serialDataLineIn,
    output var  logic        serialDataLineOut,
    output var  logic        serialDataLineOe,
    output var  logic        irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        iasr_pkg::iasr_sync_t       sy;
        logic                       awHave;
        logic [3:0]                 awAddr;
        logic                       wHave;
        logic [31:0]                wData;
        logic [3:0]                 wStrb;
        logic                       bValid;
        logic [1:0]                 bResp;
        logic                       rValid;
        logic [31:0]                rData;
        logic [1:0]                 rResp;
        iasr_pkg::iasr_state_t      st;
        logic [7:0]                 serial_shift_reg;
        logic                       output_latch;
        logic                       rxBit;
        logic                       sclLow;
        logic [3:0]                 divCnt;
        logic [3:0]                 bitCnt;
        logic                       addrPhase;
        logic                       rwBit;
        logic                       waitLow;
        logic                       wait_timing_select;
        logic                       stop_irq_enable;
        logic                       stopPending;
        logic [6:0]                 own_slave_address;
        logic [7:0]                 bus_status_reg;
        logic [iasr_pkg::IRQ_N-1:0] irqStat;
        logic [iasr_pkg::IRQ_N-1:0] irqMask;
        logic                       sclOe;
        logic                       sdaOe;
        logic                       irq;
    } iasr_regs_t;

    iasr_regs_t q, d;

    logic sclNow, sclOld, sdaNow, sdaOld;
    logic sclRise, sclFall, startCond, stopCond;
    logic wrFire, rdFire, lostBit, txBit;
    logic [7:0] stNext, nb;

    // Change counts when 2nd and 3rd stages differ
    assign sclNow    = q.sy.scl[1];
    assign sclOld    = q.sy.scl[2];
    assign sdaNow    = q.sy.sda[1];
    assign sdaOld    = q.sy.sda[2];
    assign sclRise   = sclNow & ~sclOld;
    assign sclFall   = ~sclNow & sclOld;
    assign startCond = sclNow & sclOld & sdaOld & ~sdaNow;
    assign stopCond  = sclNow & sclOld & ~sdaOld & sdaNow;

    always_comb begin
        d = q;
        d.sy.scl = {q.sy.scl[1:0], serialClockLineIn};
        d.sy.sda = {q.sy.sda[1:0], serialDataLineIn};
        stNext = q.bus_status_reg;
        txBit = q.bus_status_reg[iasr_pkg::ST_TRC]
            | (q.addrPhase & q.bus_status_reg[iasr_pkg::ST_MST]);
        nb = {q.serial_shift_reg[6:0], q.rxBit};
        lostBit = 1'b0;

        // ------------------------------------------------------------
        // AXI4-Lite write and read handshakes
        // ------------------------------------------------------------
        if (s_axi_awvalid && !q.awHave) begin
            d.awHave = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wHave) begin
            d.wHave = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end
        wrFire = q.awHave && q.wHave && !q.bValid;
        if (q.bValid && s_axi_bready) begin
            d.bValid = 1'b0;
        end
        rdFire = s_axi_arvalid && !q.rValid;
        // Clear first, so an event in the same cycle wins
        if (rdFire && s_axi_araddr == iasr_pkg::ADDR_IRQ) begin
            d.irqStat = '0;
        end
        if (q.rValid && s_axi_rready) begin
            d.rValid = 1'b0;
        end

        // ------------------------------------------------------------
        // Bit engine
        // ------------------------------------------------------------
        if (sclRise && q.st != iasr_pkg::IASR_IDLE) begin
            // Compare what we drive with what the bus shows
            if (q.sdaOe == 1'b0 && q.output_latch == 1'b1 && !sdaNow
                && q.bus_status_reg[iasr_pkg::ST_MST]
                && q.bitCnt != iasr_pkg::BIT_ACK) begin
                lostBit = 1'b1;
            end
            if (q.bitCnt != iasr_pkg::BIT_ACK) begin
                d.rxBit = sdaNow;
            end else begin
                stNext[iasr_pkg::ST_ACK] = ~sdaNow;
            end
        end

        if (sclFall && q.st != iasr_pkg::IASR_IDLE
            && q.st != iasr_pkg::IASR_LOST) begin
            d.bitCnt = q.bitCnt + 4'h1;
            if (q.bitCnt < iasr_pkg::BIT_ACK) begin
                d.serial_shift_reg = nb;
            end
            if (q.bitCnt == iasr_pkg::BIT_ACK - 4'h1) begin
                if (q.addrPhase) begin
                    d.rwBit = nb[0];
                    if (q.bus_status_reg[iasr_pkg::ST_MST]) begin
                        stNext[iasr_pkg::ST_TRC] = ~nb[0];
                    end else if (nb[7:1] == q.own_slave_address) begin
                        stNext[iasr_pkg::ST_COI] = 1'b1;
                        stNext[iasr_pkg::ST_TRC] = nb[0];
                    end else if (nb[7:4] == iasr_pkg::EXT_PREFIX) begin
                        stNext[iasr_pkg::ST_EXC] = 1'b1;
                    end
                end
                if (!q.wait_timing_select) begin
                    d.waitLow = 1'b1;
                    d.irqStat[iasr_pkg::IRQ_XFER] = 1'b1;
                end
            end else if (q.bitCnt == iasr_pkg::BIT_ACK) begin
                d.bitCnt = iasr_pkg::BIT_ZERO;
                d.addrPhase = 1'b0;
                if (q.wait_timing_select) begin
                    d.waitLow = 1'b1;
                    d.irqStat[iasr_pkg::IRQ_XFER] = 1'b1;
                end
            end else if (q.bitCnt == iasr_pkg::BIT_LAST) begin
                // First fall after a start carries no bit
                d.bitCnt = iasr_pkg::BIT_ZERO;
            end
        end

        // Drive next bit while clock is low
        d.output_latch = q.serial_shift_reg[7];
        if (q.bitCnt == iasr_pkg::BIT_ACK) begin
            d.sdaOe = q.addrPhase
                ? (stNext[iasr_pkg::ST_COI] & ~stNext[iasr_pkg::ST_MST])
                : (~txBit & (stNext[iasr_pkg::ST_COI]
                | q.bus_status_reg[iasr_pkg::ST_MST]));
        end else if (!sclNow) begin
            // Data may only move while the clock is low
            d.sdaOe = txBit & ~q.output_latch & (q.st == iasr_pkg::IASR_ACTIVE);
        end
        d.sclOe = q.waitLow | (q.sclLow & q.bus_status_reg[iasr_pkg::ST_MST]);
        // Own clock as master; high half waits for a stretched line
        if (q.bus_status_reg[iasr_pkg::ST_MST] && q.st == iasr_pkg::IASR_ACTIVE
            && !q.waitLow && (q.sclLow || sclNow)) begin
            d.divCnt = q.divCnt + 4'h1;
            if (q.divCnt == iasr_pkg::SCL_HALF) begin
                d.divCnt = 4'h0;
                d.sclLow = ~q.sclLow;
            end
        end

        // ------------------------------------------------------------
        // Arbitration
        // ------------------------------------------------------------
        if (lostBit) begin
            stNext[iasr_pkg::ST_ALD] = 1'b1;
            stNext[iasr_pkg::ST_MST] = 1'b0;
            d.irqStat[iasr_pkg::IRQ_ALD] = 1'b1;
            d.sdaOe = 1'b0;
            d.sclLow = 1'b0;
            d.st = q.addrPhase ? iasr_pkg::IASR_ACTIVE : iasr_pkg::IASR_LOST;
            stNext[iasr_pkg::ST_TRC] = 1'b0;
        end

        if (startCond) begin
            if (q.bus_status_reg[iasr_pkg::ST_MST]
                && q.st != iasr_pkg::IASR_RESTART
                && q.st != iasr_pkg::IASR_MSTART) begin
                stNext[iasr_pkg::ST_ALD] = 1'b1;
                d.irqStat[iasr_pkg::IRQ_ALD] = 1'b1;
                stNext[iasr_pkg::ST_MST] = 1'b0;
            end else begin
                stNext[iasr_pkg::ST_ALD] = 1'b0;
            end
            stNext[iasr_pkg::ST_START] = 1'b1;
            stNext[iasr_pkg::ST_STOP] = 1'b0;
            stNext[iasr_pkg::ST_COI] = 1'b0;
            stNext[iasr_pkg::ST_EXC] = 1'b0;
            stNext[iasr_pkg::ST_TRC] = q.st == iasr_pkg::IASR_RESTART
                || (q.st == iasr_pkg::IASR_MSTART);
            d.st = iasr_pkg::IASR_ACTIVE;
            d.addrPhase = 1'b1;
            d.bitCnt = iasr_pkg::BIT_LAST;
            // Own start: hold the clock low until the address is written
            if (q.st == iasr_pkg::IASR_MSTART) begin
                d.waitLow = 1'b1;
                d.sclLow = 1'b1;
                d.divCnt = 4'h0;
            end
        end

        if (stopCond) begin
            if (q.bus_status_reg[iasr_pkg::ST_MST]
                && q.st != iasr_pkg::IASR_MSTOP) begin
                stNext[iasr_pkg::ST_ALD] = 1'b1;
                d.irqStat[iasr_pkg::IRQ_ALD] = 1'b1;
            end
            stNext = 8'h00 | (stNext & (8'h01 << iasr_pkg::ST_ALD));
            stNext[iasr_pkg::ST_STOP] = 1'b1;
            if (q.stop_irq_enable) begin
                d.irqStat[iasr_pkg::IRQ_STOP] = 1'b1;
            end
            d.st = iasr_pkg::IASR_IDLE;
            d.sdaOe = 1'b0;
            d.waitLow = 1'b0;
        end

        // Own restart and stop attempts: data must be high to go
        if ((q.st == iasr_pkg::IASR_RESTART || q.st == iasr_pkg::IASR_MSTOP)
            && sclRise && !sdaNow && !q.sdaOe) begin
            if (q.st == iasr_pkg::IASR_RESTART) begin
                stNext[iasr_pkg::ST_ALD] = 1'b1;
            end else begin
                stNext[iasr_pkg::ST_ALD] = 1'b1;
            end
            stNext[iasr_pkg::ST_MST] = 1'b0;
            d.irqStat[iasr_pkg::IRQ_ALD] = 1'b1;
            d.st = iasr_pkg::IASR_LOST;
        end
        if (q.st == iasr_pkg::IASR_MSTART && !q.sdaOe) begin
            d.sdaOe = 1'b1;
        end
        if ((q.st == iasr_pkg::IASR_RESTART || q.st == iasr_pkg::IASR_MSTOP)
            && sclNow) begin
            d.sdaOe = q.st == iasr_pkg::IASR_RESTART ? 1'b0 : 1'b0;
        end

        if (stNext[iasr_pkg::ST_EXC] && !q.bus_status_reg[iasr_pkg::ST_EXC]) begin
            d.irqStat[iasr_pkg::IRQ_EXC] = 1'b1;
        end
        d.bus_status_reg = stNext;

        // ------------------------------------------------------------
        // Register writes and reads
        // ------------------------------------------------------------
        if (wrFire) begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.bValid = 1'b1;
            d.bResp = iasr_pkg::RESP_OKAY;
            case (q.awAddr)
                iasr_pkg::ADDR_CTRL: begin
                    d.wait_timing_select = q.wData[iasr_pkg::CTRL_WAITT];
                    d.stop_irq_enable = q.wData[iasr_pkg::CTRL_SPIE];
                    d.own_slave_address =
                        q.wData[iasr_pkg::CTRL_ADDR_HI:iasr_pkg::CTRL_ADDR_LO];
                    d.irqMask =
                        q.wData[iasr_pkg::CTRL_MASK_HI:iasr_pkg::CTRL_MASK_LO];
                    if (q.wData[iasr_pkg::CTRL_RELEASE]) begin
                        d.waitLow = 1'b0;
                    end
                    if (q.wData[iasr_pkg::CTRL_START]) begin
                        d.st = q.bus_status_reg[iasr_pkg::ST_MST]
                            ? iasr_pkg::IASR_RESTART : iasr_pkg::IASR_MSTART;
                        d.bus_status_reg[iasr_pkg::ST_MST] = 1'b1;
                        d.waitLow = 1'b0;
                    end
                    if (q.wData[iasr_pkg::CTRL_STOP]) begin
                        d.st = iasr_pkg::IASR_MSTOP;
                        d.waitLow = 1'b0;
                    end
                end
                iasr_pkg::ADDR_SHIFT: begin
                    d.serial_shift_reg = q.wData[7:0];
                    d.waitLow = 1'b0;
                end
                iasr_pkg::ADDR_IRQ: ;
                default: d.bResp = iasr_pkg::RESP_SLVERR;
            endcase
        end
        if (rdFire) begin
            d.rValid = 1'b1;
            d.rResp = iasr_pkg::RESP_OKAY;
            d.rData = '0;
            case (s_axi_araddr)
                iasr_pkg::ADDR_CTRL: d.rData[iasr_pkg::CTRL_SPIE] = q.stop_irq_enable;
                iasr_pkg::ADDR_STATUS: d.rData[7:0] = q.bus_status_reg;
                iasr_pkg::ADDR_SHIFT: d.rData[7:0] = q.serial_shift_reg;
                iasr_pkg::ADDR_IRQ: begin
                    d.rData[iasr_pkg::IRQ_N-1:0] = q.irqStat;
                end
                default: d.rResp = iasr_pkg::RESP_SLVERR;
            endcase
        end
        d.irq = |(d.irqStat & q.irqMask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.sy <= '1;
            q.serial_shift_reg <= iasr_pkg::BYTE_ONES;
            q.output_latch <= 1'b1;
            q.st <= iasr_pkg::IASR_IDLE;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = ~q.awHave;
    assign s_axi_wready  = ~q.wHave;
    assign s_axi_bvalid  = q.bValid;
    assign s_axi_bresp   = q.bResp;
    assign s_axi_arready = ~q.rValid;
    assign s_axi_rvalid  = q.rValid;
    assign s_axi_rdata   = q.rData;
    assign s_axi_rresp   = q.rResp;
    assign serialClockLineOut = 1'b0;
    assign serialClockLineOe  = q.sclOe;
    assign serialDataLineOut  = 1'b0;
    assign serialDataLineOe   = q.sdaOe;
    assign irq = q.irq;

endmodule : iasr_shifter
`default_nettype wire

// ### tb/iasr_shifter_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module iasr_shifter_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        serialClockLineIn,
    input wire logic        serialClockLineOe,
    input wire logic        serialDataLineIn,
    input wire logic        serialDataLineOut,
    input wire logic        serialDataLineOe,
    input wire logic        irq
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [3:0] idleCnt_q;
    logic [3:0] idleCnt_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Idle count lets a late-arriving bus event not mask an irq clear
    always_comb idleCnt_d = !(serialClockLineIn && serialDataLineIn) ? 4'h0
        : idleCnt_q + {3'h0, idleCnt_q != 4'hF};
    always_ff @(posedge clk or posedge rst)
        if (rst) idleCnt_q <= 4'h0;
        else idleCnt_q <= idleCnt_d;
    chk_sda_pull_only: assert property (!serialDataLineOut)
        else $error("Data line driven high");
    chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("Write answer dropped early");
    chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read answer changed early");
    chk_read_refused: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rvalid
        && s_axi_rresp == iasr_pkg::RESP_SLVERR)
        else $error("Unmapped read not refused");
    chk_read_okay: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rvalid
        && s_axi_rresp == iasr_pkg::RESP_OKAY)
        else $error("Mapped read refused");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("Write not answered");
    chk_reset_quiet: assert property ($fell(rst) |-> !irq
        && !serialClockLineOe && !serialDataLineOe)
        else $error("Outputs active after reset");
    chk_irq_read_clears: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == iasr_pkg::ADDR_IRQ && idleCnt_q == 4'hF
        |-> ##[1:3] !irq) else $error("Irq not cleared by read");
    cover property (s_axi_rvalid && s_axi_rresp == iasr_pkg::RESP_SLVERR);
    cover property ($rose(irq));
    cover property ($fell(serialClockLineOe) && !serialDataLineOe);
endmodule : iasr_shifter_monitor
`default_nettype wire

// ### tb/iasr_bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
module iasr_bus_partner (
    input  wire logic sclIn,
    input  wire logic sdaIn,
    output var  logic sclOe,
    output var  logic sdaOe
);
    // ----------------------------------------------------------------
    // Other bus party: plain slave, or master clocking at 64 ns
    // ----------------------------------------------------------------
    int         clashBit = -1;
    logic       slaveOn  = 1'h0;
    logic [7:0] got;
    initial begin
        sclOe = 1'h0;
        sdaOe = 1'h0;
    end
    // Clash pulls data low on one bit, as a winning master would
    always begin : slv
        @(negedge sdaIn iff (sclIn && slaveOn));
        for (int i = 7; i >= 0; i--) begin
            @(negedge sclIn);
            #8 sdaOe = (i == clashBit);
            @(posedge sclIn);
            got[i] = sdaIn;
        end
        @(negedge sclIn);
        #8 sdaOe = 1'h1;
        @(negedge sclIn);
        #8 sdaOe = 1'h0;
    end
    task automatic mStart();
        sdaOe = 1'h1;
        #32 sclOe = 1'h1;
        #16;
    endtask : mStart
    // Waiting on the line honours the device's clock stretch
    task automatic mBit(input logic b);
        sdaOe = !b;
        #16 sclOe = 1'h0;
        wait (sclIn);
        #32 sclOe = 1'h1;
        #16;
    endtask : mBit
    task automatic mByte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) mBit(d[i]);
        sdaOe = 1'h0;
        #16 sclOe = 1'h0;
        wait (sclIn);
        #16 ack = !sdaIn;
        #16 sclOe = 1'h1;
        #16;
    endtask : mByte
    task automatic mStop();
        disable slv;
        sclOe = 1'h1;
        #16 sdaOe = 1'h1;
        #16 sclOe = 1'h0;
        wait (sclIn);
        #32 sdaOe = 1'h0;
        #32;
    endtask : mStop
endmodule : iasr_bus_partner
`default_nettype wire

// ### tb/iasr_shifter_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module iasr_shifter_tb_top;
    // ----------------------------------------------------------------
    // Bench
    // ----------------------------------------------------------------
    localparam logic [31:0] CTL = 32'h000F2A04;
    logic        clk, rst, irq, a1, a2;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, st, iq, sh, q;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, pScl, pSda;
    logic        serialClockLineIn, serialClockLineOut, serialClockLineOe;
    logic        serialDataLineIn, serialDataLineOut, serialDataLineOe;
    logic [7:0]  dat;
    int          n_mismatch = 0;
    int          compares = 0;
    // Pull-ups: a line is low while any party pulls it
    assign serialClockLineIn = !(serialClockLineOe || pScl);
    assign serialDataLineIn  = !(serialDataLineOe || pSda);
    iasr_shifter dut_u (.*);
    iasr_bus_partner peer_u (
        .sclIn (serialClockLineIn),
        .sdaIn (serialDataLineIn),
        .sclOe (pScl),
        .sdaOe (pSda)
    );
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("Mismatches %0d of %0d compares", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [31:0] d);
        logic ra, rw, done;
        done = 1'h0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_arvalid <= !w;
        s_axi_bready  <= w;
        s_axi_rready  <= !w;
        while (!done) begin
            @(negedge clk);
            ra = w ? s_axi_awready : s_axi_arready;
            rw = s_axi_wready;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge clk);
            if (ra) s_axi_awvalid <= 1'h0;
            if (ra) s_axi_arvalid <= 1'h0;
            if (rw) s_axi_wvalid <= 1'h0;
            if (done) s_axi_bready <= 1'h0;
            if (done) s_axi_rready <= 1'h0;
        end
    endtask : xfer
    // Service one interrupt, then release the clock-low wait
    task automatic svc(input logic [31:0] c);
        for (int t = 0; t < 5000 && irq !== 1'h1; t++) @(negedge clk);
        xfer(1'h0, iasr_pkg::ADDR_STATUS, 32'h0);
        st = q;
        xfer(1'h0, iasr_pkg::ADDR_IRQ, 32'h0);
        iq = q;
        xfer(1'h0, iasr_pkg::ADDR_SHIFT, 32'h0);
        sh = q;
        xfer(1'h1, iasr_pkg::ADDR_CTRL, c | 32'h10);
    endtask : svc
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        rst = 1'h1;
        void'($urandom(65));
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        xfer(1'h0, iasr_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'h0);
        xfer(1'h0, iasr_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        xfer(1'h0, 4'h6, 32'h0);
        chk({30'h0, r}, {30'h0, iasr_pkg::RESP_SLVERR});
        xfer(1'h1, 4'h2, 32'h0);
        chk({30'h0, r}, {30'h0, iasr_pkg::RESP_SLVERR});
        // Own address phase lost to a low data bit
        peer_u.slaveOn = 1'h1;
        peer_u.clashBit = 4;
        xfer(1'h1, iasr_pkg::ADDR_CTRL, CTL | 32'h1);
        q = '0;
        for (int t = 0; t < 50 && q[iasr_pkg::ST_START] !== 1'h1; t++)
            xfer(1'h0, iasr_pkg::ADDR_STATUS, 32'h0);
        xfer(1'h1, iasr_pkg::ADDR_SHIFT, 32'hB4);
        svc(CTL);
        chk(st & 32'hC0, 32'h40);
        chk(iq & 32'h2, 32'h2);
        chk({29'h0, peer_u.got[7:5]}, 32'h5);
        chk({31'h0, serialDataLineOe}, 32'h0);
        peer_u.mStop();
        repeat (40) @(posedge clk);
        xfer(1'h0, iasr_pkg::ADDR_STATUS, 32'h0);
        chk(q & 32'h40, 32'h40);
        xfer(1'h0, iasr_pkg::ADDR_IRQ, 32'h0);
        // Addressed as slave, stop interrupt off then on
        peer_u.slaveOn = 1'h0;
        for (int k = 0; k < 2; k++) begin
            dat = 8'($urandom);
            xfer(1'h1, iasr_pkg::ADDR_CTRL, CTL | 32'(k * 8));
            fork
                begin
                    peer_u.mStart();
                    peer_u.mByte(8'h54, a1);
                    peer_u.mByte(dat, a2);
                end
                svc(CTL | 32'(k * 8));
            join
            chk({31'h0, a1}, 32'h1);
            chk(st & 32'h58, 32'h10);
            chk(iq & 32'h1, 32'h1);
            fork
                peer_u.mStop();
                svc(CTL | 32'(k * 8));
            join
            chk(sh & 32'hFF, {24'h0, dat});
            repeat (40) @(posedge clk);
            chk({31'h0, irq}, 32'(k));
            xfer(1'h0, iasr_pkg::ADDR_IRQ, 32'h0);
        end
        tally_and_finish();
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : iasr_shifter_tb_top
bind iasr_shifter iasr_shifter_monitor mon_u (.*);
`default_nettype wire
